// ---- src/mmc_pkg.sv ----
// constants and carrier types for the memory-mapped cache access block
package mmc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int WAYS = 4;
	localparam int SETS = 256;
	localparam int LINE_WORDS = 4;
	localparam int TAG_W = 22;
	localparam int LRU_W = 6;
	localparam int SHADOW_W = 3;
	// address decode
	localparam int REGION_MSB = 31;
	localparam int REGION_LSB = 24;
	localparam logic [7:0] REGION_TAG = 8'hF0;
	localparam logic [7:0] REGION_DATA = 8'hF1;
	localparam int IDX_MSB = 11;
	localparam int IDX_LSB = 4;
	localparam int WAY_MSB = 12;
	localparam int WAY_LSB = 11;
	localparam int CMP_BIT = 3;
	localparam int LW_MSB = 3;
	localparam int LW_LSB = 2;
	// tag-region data word layout
	localparam int TAG_MSB = 31;
	localparam int TAG_LSB = 10;
	localparam int LRU_MSB = 9;
	localparam int LRU_LSB = 4;
	localparam int U_BIT = 1;
	localparam int V_BIT = 0;
	localparam logic [3:0] BE_FULL = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [LRU_W-1:0] LRU_RST = 6'h00;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	typedef logic [1:0] way_t;
	typedef logic [7:0] set_t;
	typedef logic [TAG_W-1:0] tag_t;

	typedef struct packed {
		set_t set;
		way_t way;
		tag_t tag;
	} fill_req_t;

	typedef struct packed {
		set_t set;
		tag_t tag;
	} lookup_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LINE_WORDS*DATA_W-1:0] data;
	} wb_line_t;
endpackage

// ---- src/mm_cache_access.sv ----
// memory-mapped tag and data array access for a four-way 16-kbyte cache
`timescale 1ns/10ps

// Functional notes
// - F0 region is tags, F1 is data, privileged
// - longword accesses only, no instruction fetch
// - tag access: index 11:4, way 12:11
// - compare flag set: write only matching way
// - compare miss: no write, way field ignored
// - compare flag clear: write selected entry directly
// - tag write stores tag, valid, dirty, lru
// - tag translated when mmu on, physical stored
// - tag read returns entry fields, no compare
// - clearing valid on dirty line writes back
// - line fill stores zero shadow tag bits
// - data access: longword select bits 3:2
// - data access moves exactly one longword
// - hit needs tag match and valid set
// - write-back through one-line buffer, cache usable
module mm_cache_access
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic priv_i,
	input wire logic ifetch_i,
	input wire logic [31:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic avs_waitrequest_o,
	output logic [31:0] avs_readdata_o,
	output logic [1:0] avs_response_o,
	input wire logic mmu_en_i,
	output mmc_pkg::tag_t xlat_vpn_o,
	input wire mmc_pkg::tag_t xlat_ppn_i,
	input wire logic fill_valid_i,
	input wire mmc_pkg::fill_req_t fill_i,
	output logic fill_ready_o,
	input wire logic lookup_valid_i,
	input wire mmc_pkg::lookup_req_t lookup_i,
	output logic hit_o,
	output mmc_pkg::way_t hit_way_o,
	output logic wb_valid_o,
	input wire logic wb_ready_i,
	output mmc_pkg::wb_line_t wb_line_o
);
	import mmc_pkg::*;

	function automatic set_t f_set(input logic [ADDR_W-1:0] a);
		return a[IDX_MSB:IDX_LSB];
	endfunction

	function automatic way_t f_way(input logic [ADDR_W-1:0] a);
		return a[WAY_MSB:WAY_LSB];
	endfunction

	function automatic way_t f_enc(input logic [WAYS-1:0] m);
		way_t w;
		w = 2'h0;
		for (int i = 0; i < WAYS; i++)
		begin
			if (m[i])
				w = way_t'(i);
		end
		return w;
	endfunction

	logic rst_q1;
	logic rst_n;
	tag_t tag_mem [WAYS][SETS];
	logic v_mem [WAYS][SETS];
	logic u_mem [WAYS][SETS];
	logic [LRU_W-1:0] lru_mem [SETS];
	logic [DATA_W-1:0] data_mem [WAYS*SETS*LINE_WORDS];

	logic rd_done;
	logic next_rd_done;
	logic [31:0] next_readdata;
	logic [1:0] rd_resp;
	logic [1:0] next_rd_resp;
	logic next_hit;
	way_t next_hit_way;
	logic next_wb_valid;
	wb_line_t next_wb_line;

	logic is_tag;
	logic is_data;
	logic legal;
	logic cmp;
	logic wb_stall;
	logic do_write;
	set_t idx;
	way_t way;
	tag_t ptag;
	logic [WAYS-1:0] match;
	logic cmp_hit;
	logic tag_we;
	way_t tw_way;
	logic new_v;
	logic need_wb;
	logic dat_we;
	logic fill_we;
	logic [11:0] dw_idx;
	logic [WAYS-1:0] lk_match;

	// reset is released through two flops
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	always_comb
	begin
		is_tag = avs_address_i[REGION_MSB:REGION_LSB] == REGION_TAG;
		is_data = avs_address_i[REGION_MSB:REGION_LSB] == REGION_DATA;
		legal = priv_i && !ifetch_i && avs_byteenable_i == BE_FULL
			&& (is_tag || is_data);
		idx = f_set(avs_address_i);
		way = f_way(avs_address_i);
		cmp = avs_address_i[CMP_BIT];
		dw_idx = {way, idx, avs_address_i[LW_MSB:LW_LSB]};
		// tag is translated before compare and store
		xlat_vpn_o = avs_writedata_i[TAG_MSB:TAG_LSB];
		ptag = mmu_en_i ? xlat_ppn_i : avs_writedata_i[TAG_MSB:TAG_LSB];
		// a way hits only with valid set
		for (int i = 0; i < WAYS; i++)
		begin
			match[i] = v_mem[i][idx] && tag_mem[i][idx] == ptag;
			lk_match[i] = v_mem[i][lookup_i.set]
				&& tag_mem[i][lookup_i.set] == lookup_i.tag;
		end
		cmp_hit = |match;
		// a full buffer holds off only tag writes; data stays reachable
		wb_stall = wb_valid_o && !wb_ready_i;
		avs_waitrequest_o = !ce_i || (avs_read_i && !rd_done)
			|| (avs_write_i && legal && is_tag && wb_stall);
		avs_response_o = avs_read_i ? rd_resp
			: (legal ? RESP_OKAY : RESP_SLVERR);
		do_write = avs_write_i && !avs_waitrequest_o && legal;
		// compare mode writes the matching way
		// compare miss leaves the array alone
		// direct mode writes the addressed way
		tag_we = do_write && is_tag && (!cmp || cmp_hit);
		tw_way = cmp ? f_enc(match) : way;
		new_v = avs_writedata_i[V_BIT];
		// invalidating a dirty line queues a write-back
		need_wb = tag_we && v_mem[tw_way][idx] && u_mem[tw_way][idx]
			&& !new_v;
		dat_we = do_write && is_data;
		fill_ready_o = ce_i && !tag_we;
		fill_we = fill_valid_i && fill_ready_o;
	end

	always_comb
	begin
		next_rd_done = rd_done;
		next_readdata = avs_readdata_o;
		next_rd_resp = rd_resp;
		next_hit = hit_o;
		next_hit_way = hit_way_o;
		next_wb_valid = wb_valid_o;
		next_wb_line = wb_line_o;
		if (ce_i)
		begin
			// reads take one wait state so data leaves a flop
			next_rd_done = avs_read_i && !rd_done;
			if (avs_read_i && !rd_done)
			begin
				next_rd_resp = legal ? RESP_OKAY : RESP_SLVERR;
				next_readdata = RDATA_RST;
				// fields of the addressed entry, no compare
				if (legal && is_tag)
				begin
					next_readdata[TAG_MSB:TAG_LSB] = tag_mem[way][idx];
					next_readdata[LRU_MSB:LRU_LSB] = lru_mem[idx];
					next_readdata[U_BIT] = u_mem[way][idx];
					next_readdata[V_BIT] = v_mem[way][idx];
				end
				else if (legal && is_data)
					next_readdata = data_mem[dw_idx];
			end
			next_hit = lookup_valid_i && |lk_match;
			next_hit_way = f_enc(lk_match);
			// one-line buffer drains while the cache runs
			if (wb_valid_o && wb_ready_i)
				next_wb_valid = 1'b0;
			if (need_wb)
			begin
				next_wb_valid = 1'b1;
				next_wb_line.addr = {tag_mem[tw_way][idx], idx, 2'h0};
				for (int k = 0; k < LINE_WORDS; k++)
					next_wb_line.data[k*DATA_W +: DATA_W] =
						data_mem[{tw_way, idx, 2'(k)}];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_done <= 1'b0;
			avs_readdata_o <= RDATA_RST;
			rd_resp <= RESP_OKAY;
			hit_o <= 1'b0;
			hit_way_o <= 2'h0;
			wb_valid_o <= 1'b0;
			wb_line_o <= '0;
		end
		else
		begin
			rd_done <= next_rd_done;
			avs_readdata_o <= next_readdata;
			rd_resp <= next_rd_resp;
			hit_o <= next_hit;
			hit_way_o <= next_hit_way;
			wb_valid_o <= next_wb_valid;
			wb_line_o <= next_wb_line;
		end
	end

	// valid and dirty start clear; tags and data need no reset
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < WAYS; i++)
				for (int j = 0; j < SETS; j++)
				begin
					v_mem[i][j] <= 1'b0;
					u_mem[i][j] <= 1'b0;
				end
		end
		else if (tag_we)
		begin
			// valid and dirty into the chosen entry; tag and lru are written below
			v_mem[tw_way][idx] <= new_v;
			u_mem[tw_way][idx] <= avs_writedata_i[U_BIT];
		end
		else if (fill_we)
		begin
			v_mem[fill_i.way][fill_i.set] <= 1'b1;
			u_mem[fill_i.way][fill_i.set] <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (tag_we)
		begin
			tag_mem[tw_way][idx] <= ptag;
			lru_mem[idx] <= avs_writedata_i[LRU_MSB:LRU_LSB];
		end
		else if (fill_we)
		begin
			// shadow bits stored as zero on a fill
			tag_mem[fill_i.way][fill_i.set] <=
				{{SHADOW_W{1'b0}}, fill_i.tag[TAG_W-SHADOW_W-1:0]};
		end
		if (dat_we)
			data_mem[dw_idx] <= avs_writedata_i;
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n);

	sequence s_cmp_miss;
		do_write && is_tag && cmp && !cmp_hit && !fill_we;
	endsequence

	sequence s_rd_start;
		ce_i && avs_read_i && !rd_done && legal && is_data;
	endsequence

	a_read_wait_state: assert property (
		avs_read_i && !avs_waitrequest_o
			|-> $past(avs_read_i) && $past(avs_waitrequest_o))
		else $error("read answered without its wait state");

	a_data_read_word: assert property (
		s_rd_start |=> avs_readdata_o == $past(data_mem[dw_idx]))
		else $error("data read returned the wrong longword");

	a_cmp_miss_idle: assert property (
		s_cmp_miss |=> !$rose(wb_valid_o)
			&& tag_mem[0][$past(idx)] == $past(tag_mem[0][idx])
			&& tag_mem[1][$past(idx)] == $past(tag_mem[1][idx])
			&& tag_mem[2][$past(idx)] == $past(tag_mem[2][idx])
			&& tag_mem[3][$past(idx)] == $past(tag_mem[3][idx]))
		else $error("compare miss changed the tag array");

	a_direct_tag_write: assert property (
		do_write && is_tag && !cmp |=> tag_mem[$past(way)][$past(idx)]
			== $past(ptag) && v_mem[$past(way)][$past(idx)] == $past(new_v))
		else $error("direct tag write not stored");

	a_priv_refused: assert property (
		avs_write_i && !priv_i && !avs_waitrequest_o
			|-> avs_response_o == RESP_SLVERR && !tag_we && !dat_we)
		else $error("unprivileged write took effect");

	a_wb_capture_line: assert property (
		need_wb |=> wb_valid_o
			&& wb_line_o.addr[TAG_MSB:TAG_LSB]
			== $past(tag_mem[tw_way][idx]))
		else $error("dirty invalidation not queued for write-back");

	a_wb_hold_line: assert property (
		wb_valid_o && !wb_ready_i && ce_i |=> wb_valid_o
			&& $stable(wb_line_o))
		else $error("write-back line lost before it was taken");

	a_fill_shadow_zero: assert property (
		fill_we |=> tag_mem[$past(fill_i.way)][$past(fill_i.set)]
			[TAG_W-1:TAG_W-SHADOW_W] == 3'h0)
		else $error("fill stored nonzero shadow bits");

	a_hit_needs_valid: assert property (
		ce_i && lookup_valid_i && !(|lk_match) |=> !hit_o)
		else $error("hit reported without a valid match");
endmodule

// ---- verif/cpu_lsu_model.sv ----
// load/store unit model: privileged longword master on avalon
`timescale 1ns/10ps
module cpu_lsu_model
(
	input wire logic clk_i,
	input wire logic wait_i,
	output logic [31:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [31:0] wdata_o,
	output logic [3:0] be_o,
	output logic priv_o,
	output logic ifetch_o
);
	initial
	begin
		{rd_o, wr_o, ifetch_o} = 3'h0;
		{addr_o, wdata_o} = 64'h0;
		be_o = 4'hF;
		priv_o = 1'h1;
	end
	// kind 0 is legal; 1 user mode, 2 fetch, 3 short size are refused
	// kind 4 keeps every attribute legal, so only the address can refuse
	task automatic access(input logic w, input logic [31:0] a,
		input logic [31:0] d, input int kind);
	begin
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		rd_o <= !w;
		wr_o <= w;
		priv_o <= (kind != 1);
		// fetch or short size only for a refusal
		ifetch_o <= (kind == 2);
		be_o <= (kind == 3) ? 4'h3 : 4'hF;
		// hold everything until the slave stops stalling
		do
			@(posedge clk_i);
		while (wait_i !== 1'h0);
		rd_o <= 1'h0;
		wr_o <= 1'h0;
	end
	endtask
endmodule

// ---- verif/mm_cache_access_tb.sv ----
// self-checking bench for the memory-mapped cache access block
`timescale 1ns/10ps
module mm_cache_access_tb;
	import mmc_pkg::*;
	logic clk_sys_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic mmu = 1'h0, fv = 1'h0, lv = 1'h0, wbr = 1'h0, ce = 1'h1;
	logic [31:0] a, wd, rdat;
	logic rd, wr, pv, ifx, wq, fr, hit, wbv;
	logic [3:0] be;
	logic [1:0] resp;
	tag_t vpn;
	way_t hw;
	fill_req_t fl = '0;
	lookup_req_t lk = '0;
	wb_line_t wbl;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	logic [33:0] expq[$];
	always #5 clk_sys_i = ~clk_sys_i;
	cpu_lsu_model lsu (.clk_i(clk_sys_i), .wait_i(wq), .addr_o(a),
		.rd_o(rd), .wr_o(wr), .wdata_o(wd), .be_o(be), .priv_o(pv),
		.ifetch_o(ifx));
	mm_cache_access uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.ce_i(ce), .priv_i(pv), .ifetch_i(ifx), .avs_address_i(a),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_waitrequest_o(wq),
		.avs_readdata_o(rdat), .avs_response_o(resp), .mmu_en_i(mmu),
		.xlat_vpn_o(vpn), .xlat_ppn_i(vpn ^ 22'h155), .fill_valid_i(fv),
		.fill_i(fl), .fill_ready_o(fr), .lookup_valid_i(lv),
		.lookup_i(lk), .hit_o(hit), .hit_way_o(hw), .wb_valid_o(wbv),
		.wb_ready_i(wbr), .wb_line_o(wbl));
	task automatic complete_run;
	begin
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
	begin
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	end
	endtask
	function automatic logic [31:0] ta(input way_t w, input logic [6:0] i,
		input logic c);
		return {8'hF0, 11'h0, w, i, c, 3'h0};
	endfunction
	function automatic logic [31:0] da(input way_t w, input logic [1:0] k);
		return {8'hF1, 11'h0, w, 7'h15, k, 2'h0};
	endfunction
	function automatic logic [31:0] tw(input tag_t t, input logic [5:0] l,
		input logic u, input logic v);
		return {t, l, 2'h0, u, v};
	endfunction
	task automatic rdx(input logic [31:0] ad, input logic [31:0] e,
		input int kind);
	begin
		expq.push_back({kind ? RESP_SLVERR : RESP_OKAY, e});
		lsu.access(1'h0, ad, 32'h0, kind);
	end
	endtask
	task automatic look(input set_t s, input tag_t t, input logic h);
	begin
		@(posedge clk_sys_i);
		lv <= 1'h1;
		lk <= '{set: s, tag: t};
		@(posedge clk_sys_i);
		lv <= 1'h0;
		#1 check(hit, h);
	end
	endtask
	// results are compared against notes in the order they were queued
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			complete_run();
		end
		else if (rd && wq === 1'h0)
			check({resp, rdat}, expq.pop_front());
	end
	initial
	begin
		tag_t t[4];
		logic [5:0] la, lb;
		logic [31:0] d[4];
		void'($urandom(32'h68ba));
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		la = $urandom;
		lb = ~la;
		// direct tag writes keep the shadow bits clear
		for (int w = 0; w < 4; w++)
		begin
			t[w] = {3'h0, 19'($urandom)};
			lsu.access(1'h1, ta(w, 7'h15, 1'h0),
				tw(t[w], w[0] ? lb : la, 1'h0, 1'h1), 0);
		end
		for (int w = 0; w < 4; w++)
			rdx(ta(w, 7'h15, 1'h0), tw(t[w], w[0] ? lb : la, 1'h0, 1'h1), 0);
		lsu.access(1'h1, ta(0, 7'h15, 1'h1), tw(t[2], ~la, 1'h0, 1'h1), 0);
		lsu.access(1'h1, ta(0, 7'h15, 1'h1), tw(~t[2], 6'h3F, 1'h0, 1'h0), 0);
		rdx(ta(2, 7'h15, 1'h0), tw(t[2], ~la, 1'h0, 1'h1), 0);
		mmu <= 1'h1;
		lsu.access(1'h1, ta(3, 7'h15, 1'h0), tw(t[3], la, 1'h0, 1'h1), 0);
		lsu.access(1'h1, ta(1, 7'h15, 1'h1), tw(t[3], lb, 1'h0, 1'h1), 0);
		rdx(ta(3, 7'h15, 1'h0), tw(t[3] ^ 22'h155, lb, 1'h0, 1'h1), 0);
		mmu <= 1'h0;
		for (int k = 0; k < 4; k++)
		begin
			d[k] = $urandom;
			lsu.access(1'h1, da(1, k), d[k], 0);
		end
		for (int k = 0; k < 4; k++)
			rdx(da(1, k), d[k], 0);
		// clock enable low stretches the read; the answer must still come
		fork
			rdx(da(1, 3), d[3], 0);
			begin
				ce <= 1'h0;
				repeat (3) @(posedge clk_sys_i);
				ce <= 1'h1;
			end
		join
		lsu.access(1'h1, ta(1, 7'h15, 1'h0), tw(t[1], lb, 1'h1, 1'h1), 0);
		lsu.access(1'h1, ta(1, 7'h15, 1'h0), tw(t[1], lb, 1'h0, 1'h0), 0);
		rdx(da(1, 2), d[2], 0);
		check(wbv, 1'h1);
		check(wbl, {t[1], 8'h95, 2'h0, d[3], d[2], d[1], d[0]});
		// a tag write must wait while the full buffer is not taken
		fork
			lsu.access(1'h1, ta(2, 7'h15, 1'h0),
				tw(t[2], ~la, 1'h0, 1'h1), 0);
			begin
				repeat (4) @(posedge clk_sys_i);
				check(wbv, 1'h1);
				wbr <= 1'h1;
			end
		join
		wbr <= 1'h0;
		@(posedge clk_sys_i);
		check(wbv, 1'h0);
		for (int k = 1; k < 4; k++)
			rdx(ta(0, 7'h15, 1'h0), 32'h0, k);
		lsu.access(1'h1, ta(0, 7'h15, 1'h0), 32'h0, 1);
		rdx(ta(0, 7'h15, 1'h0), tw(t[0], ~la, 1'h0, 1'h1), 0);
		rdx({8'hF2, 24'h0}, 32'h0, 4);
		@(posedge clk_sys_i);
		fv <= 1'h1;
		fl <= '{set: 8'hC2, way: 2'h3, tag: {3'h7, t[0][18:0]}};
		do
			@(posedge clk_sys_i);
		while (fr !== 1'h1);
		fv <= 1'h0;
		look(8'hC2, {3'h0, t[0][18:0]}, 1'h1);
		check(hw, 2'h3);
		look(8'hC2, {3'h7, t[0][18:0]}, 1'h0);
		look(8'h95, t[1], 1'h0);
		check(expq.size(), 0);
		complete_run();
	end
endmodule
